// file: inc/drive_protection_param_bank_defs.svh
// Register indices, value ranges, reset values and codes of the drive parameter bank
`ifndef DRIVE_PROTECTION_PARAM_BANK_DEFS_SVH
`define DRIVE_PROTECTION_PARAM_BANK_DEFS_SVH

// Register indices; byte address is four times the index
`define IDX_OL_MODE 16'h10b5
`define IDX_OL_LEVEL 16'h10b6
`define IDX_OL_DECEL 16'h10b7
`define IDX_OL_SRC 16'h10bb
`define IDX_LOCK_MODE 16'h10bc
`define IDX_RT_EN 16'h10c9
`define IDX_RT_VOLT 16'h10ca
`define IDX_PULL_DECEL 16'h1171
`define IDX_PULL_CUR 16'h1172
`define IDX_OL_MODE2 16'h1529
`define IDX_OL_LEVEL2 16'h152a
`define IDX_OL_DECEL2 16'h152b
`define IDX_OL_SRC2 16'h152c
`define IDX_FREQ 16'h1001
`define IDX_STATUS 16'h1180

`define NUM_SLOTS 14

// Value ranges
`define OL_MODE_MAX 16'h0002
`define OL_LEVEL_MIN 16'h07d0
`define OL_LEVEL_MAX 16'h3a98
`define OL_DECEL_MIN 16'h0001
`define OL_DECEL_MAX 16'h012c
`define OL_SRC_MAX 16'h0001
`define PULL_DECEL_MIN 16'h0001
`define PULL_DECEL_MAX 16'h7530
`define PULL_CUR_MIN 16'h00c8
`define PULL_CUR_MAX 16'h4e20
`define LOCK_MODE_MAX 16'h0003
`define RT_EN_MAX 16'h0001
`define RT_VOLT_MAX 16'h2710
`define FREQ_MAX 16'h0fa0

// Reset values
`define RST_OL_MODE 16'h0001
`define RST_OL_LEVEL 16'h2ee0
`define RST_OL_DECEL 16'h000a
`define RST_OL_SRC 16'h0000
`define RST_LOCK_MODE 16'h0001
`define RST_RT_EN 16'h0000
`define RST_RT_VOLT 16'h0000
`define RST_PULL_DECEL 16'h0005
`define RST_PULL_CUR 16'h2710
`define RST_FREQ 16'h0000

// Lock mode codes
`define LOCK_TERM_ALL 16'h0000
`define LOCK_TERM_FREQ 16'h0001
`define LOCK_ALL 16'h0002
`define LOCK_FREQ 16'h0003
`define LOCK_HIGH 16'h000a

// Status bit positions
`define ST_REF_LOCK 0
`define ST_REF_RANGE 1
`define ST_TERM 2
`define ST_LOCKED 3

`define BE_LOW 2'b11

`endif

// file: inc/drive_protection_param_bank_pkg.sv
// Types of the drive parameter bank
`include "drive_protection_param_bank_defs.svh"
package drive_protection_param_bank_pkg;

  typedef enum logic [3:0] {
    SL_OL_MODE = 4'h0,
    SL_OL_LEVEL = 4'h1,
    SL_OL_DECEL = 4'h2,
    SL_OL_SRC = 4'h3,
    SL_LOCK_MODE = 4'h4,
    SL_RT_EN = 4'h5,
    SL_RT_VOLT = 4'h6,
    SL_PULL_DECEL = 4'h7,
    SL_PULL_CUR = 4'h8,
    SL_OL_MODE2 = 4'h9,
    SL_OL_LEVEL2 = 4'ha,
    SL_OL_DECEL2 = 4'hb,
    SL_OL_SRC2 = 4'hc,
    SL_FREQ = 4'hd
  } slot_t;

  // Values handed to the motor-control logic
  typedef struct packed {
    logic [15:0] overload_limit_mode;
    logic [15:0] overload_limit_level;
    logic [15:0] overload_decel_rate;
    logic [15:0] overload_level_source;
    logic [15:0] overload_limit_mode_motor2;
    logic [15:0] overload_limit_level_motor2;
    logic [15:0] overload_decel_rate_motor2;
    logic [15:0] overload_level_source_motor2;
    logic [15:0] pullin_restart_decel_rate;
    logic [15:0] pullin_restart_current;
    logic [15:0] write_lock_mode;
    logic [15:0] ride_through_enable;
    logic [15:0] ride_through_start_voltage;
    logic [15:0] output_frequency_setting;
  } param_set_t;

  typedef struct packed {
    logic [`NUM_SLOTS-1:0][15:0] regs;
    logic wait_req;
    logic [31:0] rdata;
    logic ref_lock;
    logic ref_range;
    logic locked;
  } state_t;

endpackage

// file: logic/drive_protection_param_bank.sv
// Avalon-MM register bank for drive overload, pull-in restart, ride-through and lock parameters
`timescale 1ns/1ps
`default_nettype none
`include "drive_protection_param_bank_defs.svh"

module drive_protection_param_bank
  import drive_protection_param_bank_pkg::*;
#(
  parameter int ADDR_W = 16
) (
  input wire logic CORE_CLK_I,
  input wire logic SYS_RST_I,
  input wire logic [ADDR_W-1:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [31:0] AVS_WRITEDATA_I,
  input wire logic [3:0] AVS_BYTEENABLE_I,
  input wire logic LOCK_TERM_I,
  output logic [31:0] AVS_READDATA_O,
  output logic AVS_WAITREQUEST_O,
  output param_set_t PARAMS_O,
  output logic WRITE_LOCKED_O
);

  if (ADDR_W < 15 || ADDR_W > 18) begin : g_chk
    $error("ADDR_W must cover the highest register and stay within 18 bits");
  end

  function automatic logic [`NUM_SLOTS-1:0][15:0] reset_regs();
    logic [`NUM_SLOTS-1:0][15:0] r;
    r = '0;
    r[SL_OL_MODE] = `RST_OL_MODE;
    r[SL_OL_LEVEL] = `RST_OL_LEVEL;
    r[SL_OL_DECEL] = `RST_OL_DECEL;
    r[SL_OL_SRC] = `RST_OL_SRC;
    r[SL_LOCK_MODE] = `RST_LOCK_MODE;
    r[SL_RT_EN] = `RST_RT_EN;
    r[SL_RT_VOLT] = `RST_RT_VOLT;
    r[SL_PULL_DECEL] = `RST_PULL_DECEL;
    r[SL_PULL_CUR] = `RST_PULL_CUR;
    r[SL_OL_MODE2] = `RST_OL_MODE;
    r[SL_OL_LEVEL2] = `RST_OL_LEVEL;
    r[SL_OL_DECEL2] = `RST_OL_DECEL;
    r[SL_OL_SRC2] = `RST_OL_SRC;
    r[SL_FREQ] = `RST_FREQ;
    return r;
  endfunction

  localparam state_t RESET_STATE = '{
    regs: reset_regs(),
    wait_req: 1'b1,
    rdata: 32'h0000_0000,
    ref_lock: 1'b0,
    ref_range: 1'b0,
    locked: 1'b0
  };

  // Word index to slot; hit is low for anything unmapped
  function automatic void decode(input logic [15:0] idx, output logic hit, output slot_t sl);
    hit = 1'b1;
    sl = SL_OL_MODE;
    unique case (idx)
      `IDX_OL_MODE: sl = SL_OL_MODE;
      `IDX_OL_LEVEL: sl = SL_OL_LEVEL;
      `IDX_OL_DECEL: sl = SL_OL_DECEL;
      `IDX_OL_SRC: sl = SL_OL_SRC;
      `IDX_LOCK_MODE: sl = SL_LOCK_MODE;
      `IDX_RT_EN: sl = SL_RT_EN;
      `IDX_RT_VOLT: sl = SL_RT_VOLT;
      `IDX_PULL_DECEL: sl = SL_PULL_DECEL;
      `IDX_PULL_CUR: sl = SL_PULL_CUR;
      `IDX_OL_MODE2: sl = SL_OL_MODE2;
      `IDX_OL_LEVEL2: sl = SL_OL_LEVEL2;
      `IDX_OL_DECEL2: sl = SL_OL_DECEL2;
      `IDX_OL_SRC2: sl = SL_OL_SRC2;
      `IDX_FREQ: sl = SL_FREQ;
      default: hit = 1'b0;
    endcase
  endfunction

  function automatic logic in_range(input slot_t sl, input logic [15:0] v);
    in_range = 1'b0;
    unique case (sl)
      SL_OL_MODE, SL_OL_MODE2: in_range = v <= `OL_MODE_MAX;
      SL_OL_LEVEL, SL_OL_LEVEL2:
        in_range = v >= `OL_LEVEL_MIN && v <= `OL_LEVEL_MAX;
      SL_OL_DECEL, SL_OL_DECEL2:
        in_range = v >= `OL_DECEL_MIN && v <= `OL_DECEL_MAX;
      SL_OL_SRC, SL_OL_SRC2: in_range = v <= `OL_SRC_MAX;
      SL_PULL_DECEL:
        in_range = v >= `PULL_DECEL_MIN && v <= `PULL_DECEL_MAX;
      SL_PULL_CUR: in_range = v >= `PULL_CUR_MIN && v <= `PULL_CUR_MAX;
      SL_LOCK_MODE: in_range = v <= `LOCK_MODE_MAX;
      SL_RT_EN: in_range = v <= `RT_EN_MAX;
      SL_RT_VOLT: in_range = v <= `RT_VOLT_MAX;
      SL_FREQ: in_range = v <= `FREQ_MAX;
    endcase
  endfunction

  // Whether a write to a slot is barred by the lock mode and terminal
  function automatic logic barred(input logic [15:0] mode, input logic term, input slot_t sl);
    logic lk;
    logic fr;
    lk = sl == SL_LOCK_MODE;
    fr = sl == SL_FREQ;
    unique case (mode)
      `LOCK_TERM_ALL: barred = term && !lk;
      `LOCK_TERM_FREQ: barred = term && !lk && !fr;
      `LOCK_ALL: barred = !lk;
      `LOCK_FREQ: barred = !lk && !fr;
      default: barred = 1'b0; // High-level access code
    endcase
  endfunction

  state_t s_q;
  state_t s_d;
  logic hit;
  slot_t sl;
  logic [15:0] word_idx;
  logic aligned;
  logic is_status;
  logic req;
  logic wr_now;
  logic bar;
  logic ok_val;
  logic [3:0] status_bits;

  assign word_idx = 16'(AVS_ADDRESS_I >> 2);
  assign aligned = AVS_ADDRESS_I[1:0] == 2'b00;
  assign is_status = aligned && word_idx == `IDX_STATUS;
  assign req = AVS_READ_I || AVS_WRITE_I;

  always_comb begin
    decode(word_idx, hit, sl);
    hit = hit && aligned;
    bar = barred(s_q.regs[SL_LOCK_MODE], LOCK_TERM_I, sl);
    // Upper half must be zero and both low lanes must carry the value; partial words cannot be range checked
    ok_val = in_range(sl, AVS_WRITEDATA_I[15:0]) && AVS_WRITEDATA_I[31:16] == 16'h0000
      && AVS_BYTEENABLE_I[1:0] == `BE_LOW;
    wr_now = AVS_WRITE_I && !s_q.wait_req;
    status_bits = '0;
    status_bits[`ST_REF_LOCK] = s_q.ref_lock;
    status_bits[`ST_REF_RANGE] = s_q.ref_range;
    status_bits[`ST_TERM] = LOCK_TERM_I;
    status_bits[`ST_LOCKED] = s_q.locked;
    s_d = s_q;
    s_d.locked = barred(s_q.regs[SL_LOCK_MODE], LOCK_TERM_I, SL_OL_MODE);
    // One wait cycle per access; the write lands on the edge after the wait ends, where waitrequest is low
    if (!s_q.wait_req) begin
      s_d.wait_req = 1'b1;
    end else if (req) begin
      s_d.wait_req = 1'b0;
      if (hit) begin
        s_d.rdata = {16'h0000, s_q.regs[sl]};
      end else if (is_status) begin
        s_d.rdata = {28'h000_0000, status_bits};
      end else begin
        s_d.rdata = 32'h0000_0000;
      end
    end
    if (wr_now && is_status) begin
      if (AVS_WRITEDATA_I[`ST_REF_LOCK]) begin
        s_d.ref_lock = 1'b0;
      end
      if (AVS_WRITEDATA_I[`ST_REF_RANGE]) begin
        s_d.ref_range = 1'b0;
      end
    end
    // Refusal flags are set after the clear so a refusal is never lost
    if (wr_now && hit) begin
      if (bar) begin
        s_d.ref_lock = 1'b1;
      end else if (!ok_val) begin
        s_d.ref_range = 1'b1;
      end else begin
        s_d.regs[sl] = AVS_WRITEDATA_I[15:0];
      end
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I) begin
      s_q <= RESET_STATE;
    end else begin
      s_q <= s_d;
    end
  end

  assign AVS_READDATA_O = s_q.rdata;
  assign AVS_WAITREQUEST_O = s_q.wait_req;
  assign WRITE_LOCKED_O = s_q.locked;
  assign PARAMS_O = '{
    overload_limit_mode: s_q.regs[SL_OL_MODE],
    overload_limit_level: s_q.regs[SL_OL_LEVEL],
    overload_decel_rate: s_q.regs[SL_OL_DECEL],
    overload_level_source: s_q.regs[SL_OL_SRC],
    overload_limit_mode_motor2: s_q.regs[SL_OL_MODE2],
    overload_limit_level_motor2: s_q.regs[SL_OL_LEVEL2],
    overload_decel_rate_motor2: s_q.regs[SL_OL_DECEL2],
    overload_level_source_motor2: s_q.regs[SL_OL_SRC2],
    pullin_restart_decel_rate: s_q.regs[SL_PULL_DECEL],
    pullin_restart_current: s_q.regs[SL_PULL_CUR],
    write_lock_mode: s_q.regs[SL_LOCK_MODE],
    ride_through_enable: s_q.regs[SL_RT_EN],
    ride_through_start_voltage: s_q.regs[SL_RT_VOLT],
    output_frequency_setting: s_q.regs[SL_FREQ]
  };

  // Stored values stay in range, so a refused write that leaks shows at once
  a_mode_range: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    s_q.regs[SL_OL_MODE] <= `OL_MODE_MAX)
    else $error("overload mode out of range");

  a_mode2_range: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    s_q.regs[SL_OL_MODE2] <= `OL_MODE_MAX)
    else $error("second motor overload mode out of range");

  a_level_range: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    s_q.regs[SL_OL_LEVEL] inside {[`OL_LEVEL_MIN:`OL_LEVEL_MAX]})
    else $error("overload level out of range");

  a_level2_range: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    s_q.regs[SL_OL_LEVEL2] inside {[`OL_LEVEL_MIN:`OL_LEVEL_MAX]})
    else $error("second motor overload level out of range");

  a_decel_range: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    s_q.regs[SL_OL_DECEL] inside {[`OL_DECEL_MIN:`OL_DECEL_MAX]})
    else $error("overload decel out of range");

  a_decel2_range: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    s_q.regs[SL_OL_DECEL2] inside {[`OL_DECEL_MIN:`OL_DECEL_MAX]})
    else $error("second motor overload decel out of range");

  a_source_range: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    s_q.regs[SL_OL_SRC2] <= `OL_SRC_MAX)
    else $error("level source out of range");

  a_source1_range: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    s_q.regs[SL_OL_SRC] <= `OL_SRC_MAX)
    else $error("first motor level source out of range");

  a_pullin_range: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    s_q.regs[SL_PULL_DECEL] inside {[`PULL_DECEL_MIN:`PULL_DECEL_MAX]})
    else $error("pull-in value out of range");

  a_current_range: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    s_q.regs[SL_PULL_CUR] inside {[`PULL_CUR_MIN:`PULL_CUR_MAX]})
    else $error("pull-in current out of range");

  a_lock_hold: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    (wr_now && hit && s_q.regs[SL_LOCK_MODE] == 16'h0002 && sl != SL_LOCK_MODE)
    |=> $stable(s_q.regs) && s_q.ref_lock)
    else $error("write passed full lock");

  a_term_lock: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    (wr_now && hit && LOCK_TERM_I && s_q.regs[SL_LOCK_MODE] == 16'h0000 && sl == SL_FREQ)
    |=> $stable(s_q.regs[SL_FREQ]))
    else $error("write passed terminal lock");

  a_freq_open: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    (wr_now && sl == SL_FREQ && hit && ok_val && s_q.regs[SL_LOCK_MODE] == 16'h0003)
    |=> s_q.regs[SL_FREQ] == $past(AVS_WRITEDATA_I[15:0]))
    else $error("frequency write lost under lock 3");

  a_lock_codes: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    s_q.regs[SL_LOCK_MODE] <= 16'h0003)
    else $error("lock mode out of range");

  a_range_keep: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    (wr_now && hit && !bar && !ok_val) |=> $stable(s_q.regs) && s_q.ref_range)
    else $error("out-of-range write stored");

  a_bus_answer: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    (req && AVS_WAITREQUEST_O) |=> !AVS_WAITREQUEST_O ##1 AVS_WAITREQUEST_O)
    else $error("waitrequest did not drop for one cycle");

  a_ride_range: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    s_q.regs[SL_RT_EN] <= `RT_EN_MAX)
    else $error("ride-through value out of range");

  a_volt_range: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    s_q.regs[SL_RT_VOLT] <= `RT_VOLT_MAX)
    else $error("ride-through voltage out of range");

  // Lock behaviour, written from the lock codes rather than from the barred function, except a_good_write, which uses bar
  a_term_all: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    (wr_now && hit && LOCK_TERM_I && s_q.regs[SL_LOCK_MODE] == `LOCK_TERM_ALL
      && sl != SL_LOCK_MODE) |=> $stable(s_q.regs) && s_q.ref_lock)
    else $error("general write passed terminal lock");

  a_term_open: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    (wr_now && hit && !LOCK_TERM_I && s_q.regs[SL_LOCK_MODE] == `LOCK_TERM_ALL && ok_val)
    |=> s_q.regs[$past(sl)] == $past(AVS_WRITEDATA_I[15:0]))
    else $error("write refused with terminal off");

  a_term_freq: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    (wr_now && hit && LOCK_TERM_I && s_q.regs[SL_LOCK_MODE] == `LOCK_TERM_FREQ
      && sl != SL_LOCK_MODE && sl != SL_FREQ) |=> $stable(s_q.regs) && s_q.ref_lock)
    else $error("general write passed terminal lock with frequency open");

  a_freq_term: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    (wr_now && hit && sl == SL_FREQ && ok_val && LOCK_TERM_I
      && s_q.regs[SL_LOCK_MODE] == `LOCK_TERM_FREQ)
    |=> s_q.regs[SL_FREQ] == $past(AVS_WRITEDATA_I[15:0]))
    else $error("frequency write lost under terminal lock 1");

  a_freq_lock3: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    (wr_now && hit && s_q.regs[SL_LOCK_MODE] == `LOCK_FREQ && sl != SL_LOCK_MODE
      && sl != SL_FREQ) |=> $stable(s_q.regs) && s_q.ref_lock)
    else $error("general write passed lock 3");

  a_lock_open: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    (wr_now && hit && sl == SL_LOCK_MODE && AVS_WRITEDATA_I[15:0] <= `LOCK_MODE_MAX
      && AVS_WRITEDATA_I[31:16] == 16'h0000 && AVS_BYTEENABLE_I[1:0] == `BE_LOW)
    |=> s_q.regs[SL_LOCK_MODE] == $past(AVS_WRITEDATA_I[15:0]))
    else $error("lock register write lost");

  a_lock_refuse: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    (wr_now && hit && sl == SL_LOCK_MODE && AVS_WRITEDATA_I[15:0] > `LOCK_MODE_MAX)
    |=> $stable(s_q.regs) && s_q.ref_range)
    else $error("lock code above 3 stored");

  a_good_write: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    (wr_now && hit && !bar && ok_val)
    |=> s_q.regs[$past(sl)] == $past(AVS_WRITEDATA_I[15:0]))
    else $error("accepted write not stored");

  a_locked_flag: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    s_q.regs[SL_LOCK_MODE] == `LOCK_ALL
    |=> WRITE_LOCKED_O)
    else $error("locked flag low under full lock");

  a_status_clear: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    (wr_now && is_status && AVS_WRITEDATA_I[`ST_REF_RANGE])
    |=> !s_q.ref_range)
    else $error("range refusal flag not cleared");

  a_flag_sticky: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    (s_q.ref_lock && !(wr_now && is_status && AVS_WRITEDATA_I[`ST_REF_LOCK]))
    |=> s_q.ref_lock)
    else $error("lock refusal flag lost");

  // Bus side: one wait cycle, and read data from the addressed register or status word, zero when unmapped or misaligned
  a_wait_idle: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    (!req && AVS_WAITREQUEST_O)
    |=> AVS_WAITREQUEST_O)
    else $error("waitrequest dropped with no request");

  a_read_data: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    (AVS_READ_I && AVS_WAITREQUEST_O && hit)
    |=> !AVS_WAITREQUEST_O && AVS_READDATA_O == $past({16'h0000, s_q.regs[sl]}))
    else $error("read data does not match the register");

  a_unmapped_zero: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    (AVS_READ_I && AVS_WAITREQUEST_O && !hit && !is_status)
    |=> AVS_READDATA_O == 32'h0000_0000)
    else $error("unmapped read not zero");

  a_status_term: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    (AVS_READ_I && AVS_WAITREQUEST_O && is_status)
    |=> AVS_READDATA_O[`ST_TERM] == $past(LOCK_TERM_I))
    else $error("status terminal bit wrong");

endmodule // drive_protection_param_bank
`default_nettype wire

// file: verif/avs_host_model.sv
// Avalon-MM host model issuing single register reads and writes
`timescale 1ns/1ps
`default_nettype none
module avs_host_model (
  input wire logic clk_i,
  input wire logic waitreq_i,
  input wire logic [31:0] rdata_i,
  output logic [15:0] addr_o,
  output logic rd_o,
  output logic wr_o,
  output logic [31:0] wdata_o,
  output logic [3:0] be_o
);
  initial begin
    addr_o = 16'h0000;
    rd_o = 1'b0;
    wr_o = 1'b0;
    wdata_o = 32'h00000000;
    be_o = 4'h0;
  end

  // Caller enters just after a rising edge; request holds until waitrequest is low at an edge
  task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] d,
                      input logic [3:0] b, output logic [31:0] q);
    addr_o <= a;
    wdata_o <= d;
    be_o <= b;
    wr_o <= w;
    rd_o <= !w;
    // Waitrequest and read data are taken as they stand at the rising edge
    do @(posedge clk_i); while (waitreq_i !== 1'b0);
    q = rdata_i;
    wr_o <= 1'b0;
    rd_o <= 1'b0;
    // Idle edge so the strobe is never assigned twice in one time step
    @(posedge clk_i);
  endtask
endmodule // avs_host_model
`default_nettype wire

// file: verif/tb.sv
// Self-checking bench for the drive parameter bank
`timescale 1ns/1ps
`default_nettype none
`include "drive_protection_param_bank_defs.svh"
module tb;
  import drive_protection_param_bank_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic term = 1'b0;
  logic [15:0] addr;
  logic rd, wr, wq, locked;
  logic [31:0] wdata, rdata, q;
  logic [3:0] be;
  param_set_t params;
  int num_errors = 0;
  int check_count = 0;
  logic [15:0] model [14];
  logic [15:0] idx [14] = '{`IDX_OL_MODE, `IDX_OL_LEVEL, `IDX_OL_DECEL, `IDX_OL_SRC,
    `IDX_LOCK_MODE, `IDX_RT_EN, `IDX_RT_VOLT, `IDX_PULL_DECEL, `IDX_PULL_CUR, `IDX_OL_MODE2,
    `IDX_OL_LEVEL2, `IDX_OL_DECEL2, `IDX_OL_SRC2, `IDX_FREQ};
  logic [15:0] lo [14] = '{16'h0000, `OL_LEVEL_MIN, `OL_DECEL_MIN, 16'h0000, 16'h0000,
    16'h0000, 16'h0000, `PULL_DECEL_MIN, `PULL_CUR_MIN, 16'h0000, `OL_LEVEL_MIN,
    `OL_DECEL_MIN, 16'h0000, 16'h0000};
  logic [15:0] hi [14] = '{`OL_MODE_MAX, `OL_LEVEL_MAX, `OL_DECEL_MAX, `OL_SRC_MAX,
    `LOCK_MODE_MAX, `RT_EN_MAX, `RT_VOLT_MAX, `PULL_DECEL_MAX, `PULL_CUR_MAX, `OL_MODE_MAX,
    `OL_LEVEL_MAX, `OL_DECEL_MAX, `OL_SRC_MAX, `FREQ_MAX};
  logic [15:0] rst_v [14] = '{`RST_OL_MODE, `RST_OL_LEVEL, `RST_OL_DECEL, `RST_OL_SRC,
    `RST_LOCK_MODE, `RST_RT_EN, `RST_RT_VOLT, `RST_PULL_DECEL, `RST_PULL_CUR, `RST_OL_MODE,
    `RST_OL_LEVEL, `RST_OL_DECEL, `RST_OL_SRC, `RST_FREQ};

  drive_protection_param_bank #(.ADDR_W(16)) DUT (.CORE_CLK_I(clk), .SYS_RST_I(rst),
    .AVS_ADDRESS_I(addr), .AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdata),
    .AVS_BYTEENABLE_I(be), .LOCK_TERM_I(term), .AVS_READDATA_O(rdata),
    .AVS_WAITREQUEST_O(wq), .PARAMS_O(params), .WRITE_LOCKED_O(locked));
  avs_host_model host (.clk_i(clk), .waitreq_i(wq), .rdata_i(rdata), .addr_o(addr),
    .rd_o(rd), .wr_o(wr), .wdata_o(wdata), .be_o(be));

  initial begin
    forever #25 clk = ~clk;
  end

  // Slot 4 is the lock register and slot 13 the frequency setting
  function automatic logic allowed(int s, logic [15:0] lk, logic t);
    if (s == 4) return 1'b1;
    if (lk == `LOCK_ALL) return 1'b0;
    if (lk == `LOCK_FREQ) return s == 13;
    if (t && lk == `LOCK_TERM_ALL) return 1'b0;
    if (t && lk == `LOCK_TERM_FREQ) return s == 13;
    return 1'b1;
  endfunction

  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp, input string m);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask

  task automatic cmp_bit(input logic got, input logic exp, input string m);
    cmp_word({31'h0, got}, {31'h0, exp}, m);
  endtask

  task automatic cmp_params(input string m);
    param_set_t e;
    e = '{model[0], model[1], model[2], model[3], model[9], model[10], model[11],
      model[12], model[7], model[8], model[4], model[5], model[6], model[13]};
    check_count++;
    if (params !== e) begin
      num_errors++;
      $display("mismatch at %0t: %s got %h expected %h", $time, m, params, e);
    end
  endtask

  task automatic rd_slot(input int s);
    host.xfer(1'b0, {idx[s][13:0], 2'b00}, 32'h00000000, 4'hf, q);
    cmp_word(q, {16'h0000, model[s]}, "read back");
    cmp_params("param out");
  endtask

  task automatic wr_slot(input int s, input logic [15:0] v);
    logic ok;
    ok = allowed(s, model[4], term) && v >= lo[s] && v <= hi[s];
    host.xfer(1'b1, {idx[s][13:0], 2'b00}, {16'h0000, v}, 4'hf, q);
    if (ok) model[s] = v;
    rd_slot(s);
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    repeat (50000) @(posedge clk);
    num_errors++;
    conclude();
  end

  initial begin
    logic t;
    void'($urandom(93370));
    model = rst_v;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int s = 0; s < 14; s++) rd_slot(s);
    $display("test reset values done");
    // Range edges of every parameter apart from the lock register
    for (int s = 0; s < 14; s++) begin
      if (s == 4) continue;
      wr_slot(s, lo[s]);
      wr_slot(s, hi[s]);
      wr_slot(s, hi[s] + 16'h0001);
      if (lo[s] != 16'h0000) wr_slot(s, lo[s] - 16'h0001);
    end
    $display("test range edges done");
    // Lock mode 1 from reset, so a random terminal exercises partial locking
    for (int n = 0; n < 150; n++) begin
      int s;
      s = $urandom_range(12);
      if (s >= 4) s++;
      term <= 1'($urandom_range(1));
      @(posedge clk);
      wr_slot(s, 16'($urandom_range(int'(hi[s]) + 8)));
    end
    $display("test random writes done");
    for (int lk = 0; lk < 4; lk++) begin
      for (int ti = 0; ti < 2; ti++) begin
        t = 1'(ti);
        term <= t;
        @(posedge clk);
        wr_slot(4, 16'(lk));
        wr_slot(1, 16'($urandom_range(15000, 2000)));
        wr_slot(13, 16'($urandom_range(4000)));
        cmp_bit(locked, (lk >= 2) || t, "locked flag");
      end
    end
    cmp_params("param out");
    cmp_params("freq out");
    host.xfer(1'b0, 16'(`IDX_STATUS << 2), 32'h00000000, 4'hf, q);
    cmp_bit(q[`ST_REF_LOCK], 1'b1, "lock refusal flag");
    $display("test lock modes done");
    wr_slot(4, `LOCK_HIGH);
    wr_slot(4, 16'h0004);
    host.xfer(1'b0, 16'h0000, 32'h00000000, 4'hf, q);
    cmp_word(q, 32'h00000000, "unmapped read");
    $display("test lock code limits done");
    host.xfer(1'b0, 16'(`IDX_STATUS << 2), 32'h00000000, 4'hf, q);
    cmp_bit(q[`ST_REF_RANGE], 1'b1, "range refusal flag");
    host.xfer(1'b1, 16'(`IDX_STATUS << 2), 32'h00000003, 4'h0, q);
    host.xfer(1'b0, 16'(`IDX_STATUS << 2), 32'h00000000, 4'hf, q);
    cmp_word(q, {28'h0000000, 1'b1, term, 2'b00}, "status after clear");
    $display("test status flags done");
    conclude();
  end
endmodule // tb
`default_nettype wire
